// [design/pse_map.svh]
// Purpose: named offsets, codes and timing figures of the sensor emulator
// Assumes: included by the design files only
// Notes: definitions only
`ifndef PSE_MAP_SVH
`define PSE_MAP_SVH
`define PSE_CLK_PERIOD_NS 4
`define PSE_NS_PER_US 1000
`define PSE_CYC_PER_US (`PSE_NS_PER_US / `PSE_CLK_PERIOD_NS)
`define PSE_TMO_MIN_US 10'h00a
`define PSE_TMO_MAX_US 10'h28a
`define PSE_TMO_DEF_US 10'h064
`define PSE_REG_CTRL 4'h0
`define PSE_REG_TMO 4'h4
`define PSE_REG_STAT 4'h8
`define PSE_REG_PRE 4'hc
`define PSE_RES_DEF 5'h14
`define PSE_CTRL_DYN 5
`define PSE_PRE_AREA 31:24
`define PSE_PRE_ADDR 23:16
`define PSE_PRE_VAL 15:0
`define PSE_AREA_STD 8'ha1
`define PSE_AREA_CMD 8'ha5
`define PSE_OEM_TAG 5'h15
`define PSE_PAR_VER 8'h08
`define PSE_PAR_RES 8'h0d
`define PSE_PAR_CMDSET 8'h2a
`define PSE_PAR_LEN 6'h10
`define PSE_LEAD_LAST 2'h2
`define PSE_MODE_LAST 5'h05
`define PSE_RX_LAST 5'h17
`define PSE_INV_2PI 32'h28be60db
`define PSE_ANG_FRAC 29
`define PSE_TURN_BITS 6'h20
`define PSE_MEM_AW 10
`define PSE_MEM_DW 16
`define PSE_MEM_WORDS 1024
`endif

// [design/pse_pkg.sv]
// Purpose: types shared by the sensor emulator files
// Assumes: nothing
// Notes: mode codes are the three mode bits of a command
package pse_pkg;
	typedef enum logic [2:0] {
		PSE_M_POS = 3'h0,
		PSE_M_SEL = 3'h1,
		PSE_M_RECV = 3'h3,
		PSE_M_SEND = 3'h4,
		PSE_M_RST = 3'h5
	} pse_mode_e;
	typedef enum logic [2:0] {
		PSE_L_IDLE = 3'h0,
		PSE_L_MODE = 3'h1,
		PSE_L_RX = 3'h2,
		PSE_L_WAIT = 3'h3,
		PSE_L_TX = 3'h4,
		PSE_L_HALT = 3'h5
	} pse_lstate_e;
	typedef enum logic {
		PSE_S_IDLE = 1'h0,
		PSE_S_READ = 1'h1
	} pse_sstate_e;
endpackage

// [design/pse_mem.sv]
// Purpose: OEM parameter store, four areas of 256 words
// Assumes: single clock, one write and one read port
// Notes: read data registered, one cycle after the address
`timescale 1ns/1ps
`include "pse_map.svh"
module pse_mem (
	// clock
	input wire logic clk_sys,
	// write port
	input wire logic we,
	input wire logic [`PSE_MEM_AW-1:0] waddr,
	input wire logic [`PSE_MEM_DW-1:0] wdata,
	// read port
	input wire logic [`PSE_MEM_AW-1:0] raddr,
	output logic [`PSE_MEM_DW-1:0] rdata
);
	logic [`PSE_MEM_DW-1:0] mem [0:`PSE_MEM_WORDS-1];

	always_ff @(posedge clk_sys) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
		rdata <= mem[raddr];
	end
endmodule

// [design/pse_sensor.sv]
// Purpose: absolute position sensor emulator on a clocked serial link
// Assumes: controller clocks the link; data sampled and driven on link_clk rising
// Notes: link pair handled single ended; 3 lead-in clocks precede the mode bits
// Behaviour
// - decode six-bit mode command, five modes
// - serve version, resolution, command-set parameters
// - four OEM areas of 256 words
// - position width configurable up to 31
// - stable link clock too long resets receiver
// - pulse width limit 10 to 650 us
// - low connection enable silences all answers
// - position derived from angle in radians
// - preload writes into OEM areas
`timescale 1ns/1ps
`include "pse_map.svh"
module pse_sensor import pse_pkg::*; #(
	parameter int unsigned CYC_PER_US = `PSE_CYC_PER_US,
	parameter logic [15:0] PROTO_VER = 16'h0001,
	parameter logic [15:0] CMD_SET = 16'h0001
) (
	// system
	input wire logic clk_sys,
	input wire logic reset,
	// register port
	input wire logic [3:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	// emulated quantities
	input wire logic [31:0] angle_rad,
	input wire logic conn_en,
	// serial link
	input wire logic link_clk,
	input wire logic link_data_in,
	output logic link_data_out,
	output logic link_data_oe
);
	function automatic logic [31:0] rev16(input logic [15:0] v);
		logic [31:0] r;
		r = 32'h0;
		for (int i = 0; i < 16; i++) begin
			r[i] = v[15-i];
		end
		return r;
	endfunction

	function automatic logic is_oem(input logic [7:0] a);
		return a[7:3] == `PSE_OEM_TAG && a[0];
	endfunction

	// link side state
	pse_lstate_e lstate, next_lstate;
	logic [1:0] lead, next_lead;
	logic [4:0] lcnt, next_lcnt;
	logic [23:0] rx_sh, next_rx_sh;
	logic [2:0] req_mode, next_req_mode;
	logic [23:0] req_word, next_req_word;
	logic req_tog, next_req_tog;
	logic abort_seen, next_abort_seen;
	logic busy, next_busy;
	logic [31:0] tx_sh, next_tx_sh;
	logic [5:0] tx_cnt, next_tx_cnt;
	logic dout, next_dout, doe, next_doe;
	logic [1:0] lrst_sync, ack_sync, abt_sync;

	// system side state
	logic [4:0] res, next_res;
	logic dyn_en, next_dyn_en;
	logic [9:0] tmo_us, next_tmo_us;
	logic [31:0] rdata, next_rdata;
	logic [7:0] area, next_area;
	logic [2:0] last_mode, next_last_mode;
	logic [17:0] idle_cnt, next_idle_cnt;
	logic abort_tog, next_abort_tog, abort_pend, next_abort_pend;
	logic ack_tog, next_ack_tog;
	logic [31:0] resp_word, next_resp_word, turn, next_turn;
	logic [5:0] resp_len, next_resp_len;
	pse_sstate_e sstate, next_sstate;
	logic [1:0] req_sync, busy_sync, seen_sync, clk_sync;
	logic clk_d;

	logic [63:0] prod;
	logic [31:0] pos_val;
	logic [17:0] limit;
	logic pre_we, op_we, mem_we;
	logic [9:0] tmo_wr;
	logic [`PSE_MEM_AW-1:0] mem_waddr, mem_raddr;
	logic [15:0] mem_wdata, mem_rdata;

	// ---------------- link clock domain ----------------
	always_ff @(posedge link_clk) begin
		lrst_sync <= {lrst_sync[0], reset};
		ack_sync <= {ack_sync[0], ack_tog};
		abt_sync <= {abt_sync[0], abort_tog};
	end

	always_comb begin
		logic [2:0] m;
		m = 3'h0;
		next_lstate = lstate;
		next_lead = lead;
		next_lcnt = lcnt;
		next_rx_sh = rx_sh;
		next_req_mode = req_mode;
		next_req_word = req_word;
		next_req_tog = req_tog;
		next_abort_seen = abort_seen;
		next_tx_sh = tx_sh;
		next_tx_cnt = tx_cnt;
		next_dout = dout;
		next_doe = doe;
		// the toggle lands on the third clock of the next frame, the last lead-in clock
		if (abt_sync[1] != abort_seen) begin
			next_abort_seen = abt_sync[1];
			next_lstate = PSE_L_MODE;
			next_lead = 2'h0;
			next_lcnt = 5'h0;
			next_dout = 1'b0;
			next_doe = 1'b0;
		end else begin
			unique case (lstate)
				PSE_L_IDLE: begin
					if (lead == `PSE_LEAD_LAST) begin
						next_lead = 2'h0;
						next_lcnt = 5'h0;
						next_lstate = PSE_L_MODE;
					end else begin
						next_lead = lead + 2'h1;
					end
				end
				PSE_L_MODE: begin
					next_rx_sh = {rx_sh[22:0], link_data_in};
					next_lcnt = lcnt + 5'h1;
					if (lcnt == `PSE_MODE_LAST) begin
						m = next_rx_sh[5:3];
						next_req_mode = m;
						next_lcnt = 5'h0;
						// a corrupt or unknown command is ignored until the clock idles
						next_lstate = PSE_L_HALT;
						if (next_rx_sh[2:0] == ~m) begin
							unique case (m)
								PSE_M_POS: begin
									next_req_tog = ~req_tog;
									next_lstate = PSE_L_WAIT;
								end
								PSE_M_SEL, PSE_M_RECV, PSE_M_SEND, PSE_M_RST: begin
									next_lstate = PSE_L_RX;
								end
								default: begin
									next_lstate = PSE_L_HALT;
								end
							endcase
						end
					end
				end
				PSE_L_RX: begin
					next_rx_sh = {rx_sh[22:0], link_data_in};
					next_lcnt = lcnt + 5'h1;
					if (lcnt == `PSE_RX_LAST) begin
						next_req_word = next_rx_sh;
						next_req_tog = ~req_tog;
						next_lstate = PSE_L_WAIT;
					end
				end
				PSE_L_WAIT: begin
					if (ack_sync[1] == req_tog) begin
						if (resp_len == 6'h0) begin
							next_lstate = PSE_L_IDLE;
						end else begin
							next_tx_sh = resp_word;
							next_tx_cnt = resp_len;
							next_dout = 1'b1;
							next_doe = 1'b1;
							next_lstate = PSE_L_TX;
						end
					end
				end
				PSE_L_TX: begin
					if (tx_cnt != 6'h0) begin
						next_dout = tx_sh[0];
						next_tx_sh = {1'b0, tx_sh[31:1]};
						next_tx_cnt = tx_cnt - 6'h1;
					end else begin
						next_dout = 1'b0;
						next_doe = 1'b0;
						next_lstate = PSE_L_IDLE;
					end
				end
				PSE_L_HALT: begin
					next_lstate = PSE_L_HALT;
				end
				default: begin
					next_lstate = PSE_L_IDLE;
				end
			endcase
		end
		next_busy = next_lstate != PSE_L_IDLE || next_lead != 2'h0;
	end

	always_ff @(posedge link_clk) begin
		if (lrst_sync[1]) begin
			lstate <= PSE_L_IDLE;
			lead <= 2'h0;
			lcnt <= 5'h0;
			rx_sh <= 24'h0;
			req_mode <= 3'h0;
			req_word <= 24'h0;
			req_tog <= 1'b0;
			abort_seen <= 1'b0;
			busy <= 1'b0;
			tx_sh <= 32'h0;
			tx_cnt <= 6'h0;
			dout <= 1'b0;
			doe <= 1'b0;
		end else begin
			lstate <= next_lstate;
			lead <= next_lead;
			lcnt <= next_lcnt;
			rx_sh <= next_rx_sh;
			req_mode <= next_req_mode;
			req_word <= next_req_word;
			req_tog <= next_req_tog;
			abort_seen <= next_abort_seen;
			busy <= next_busy;
			tx_sh <= next_tx_sh;
			tx_cnt <= next_tx_cnt;
			dout <= next_dout;
			doe <= next_doe;
		end
	end

	assign link_data_out = dout;
	assign link_data_oe = doe;

	// ---------------- system clock domain ----------------
	always_ff @(posedge clk_sys) begin
		req_sync <= {req_sync[0], req_tog};
		busy_sync <= {busy_sync[0], busy};
		seen_sync <= {seen_sync[0], abort_seen};
		clk_sync <= {clk_sync[0], link_clk};
		clk_d <= clk_sync[1];
	end

	assign prod = 64'(angle_rad) * 64'(`PSE_INV_2PI);
	assign pos_val = turn >> (`PSE_TURN_BITS - {1'b0, res});
	assign limit = 18'(32'(tmo_us) * CYC_PER_US);
	assign pre_we = reg_wr && reg_addr == `PSE_REG_PRE && is_oem(reg_wdata[`PSE_PRE_AREA]);
	assign mem_we = pre_we || op_we;
	assign mem_waddr = pre_we ? {reg_wdata[26:25], reg_wdata[`PSE_PRE_ADDR]} : {area[2:1], req_word[23:16]};
	assign mem_wdata = pre_we ? reg_wdata[`PSE_PRE_VAL] : req_word[15:0];
	assign mem_raddr = {area[2:1], req_word[23:16]};
	// timeouts out of range in reg_wdata[9:0] are pulled to the nearest limit; the upper bits are dropped
	assign tmo_wr = reg_wdata[9:0] < `PSE_TMO_MIN_US ? `PSE_TMO_MIN_US :
		reg_wdata[9:0] > `PSE_TMO_MAX_US ? `PSE_TMO_MAX_US : reg_wdata[9:0];

	always_comb begin
		next_res = res;
		next_dyn_en = dyn_en;
		next_tmo_us = tmo_us;
		next_area = area;
		next_last_mode = last_mode;
		next_idle_cnt = idle_cnt;
		next_abort_tog = abort_tog;
		next_abort_pend = abort_pend;
		next_ack_tog = ack_tog;
		next_resp_word = resp_word;
		next_resp_len = resp_len;
		next_sstate = sstate;
		next_turn = prod[`PSE_ANG_FRAC +: 32];
		op_we = 1'b0;
		if (reg_wr && reg_addr == `PSE_REG_CTRL) begin
			next_res = reg_wdata[4:0];
			next_dyn_en = reg_wdata[`PSE_CTRL_DYN];
		end
		if (reg_wr && reg_addr == `PSE_REG_TMO) begin
			next_tmo_us = tmo_wr;
		end
		next_rdata = 32'h0;
		if (reg_rd) begin
			unique case (reg_addr)
				`PSE_REG_CTRL: next_rdata = {26'h0, dyn_en, res};
				`PSE_REG_TMO: next_rdata = {22'h0, tmo_us};
				`PSE_REG_STAT: next_rdata = {19'h0, last_mode, area, abort_pend, busy_sync[1]};
				default: next_rdata = 32'h0;
			endcase
		end
		// idle link clock watchdog, only while a frame is open
		if (clk_sync[1] != clk_d || !busy_sync[1]) begin
			next_idle_cnt = 18'h0;
		end else if (idle_cnt != '1) begin
			next_idle_cnt = idle_cnt + 18'h1;
		end
		if (busy_sync[1] && !abort_pend && idle_cnt >= limit) begin
			next_abort_tog = ~abort_tog;
			next_abort_pend = 1'b1;
			next_idle_cnt = 18'h0;
		end
		if (abort_pend && seen_sync[1] == abort_tog) begin
			next_abort_pend = 1'b0;
		end
		unique case (sstate)
			PSE_S_IDLE: begin
				// a preload in the same cycle holds the link request back one cycle
				if (req_sync[1] != ack_tog && !pre_we) begin
					next_ack_tog = ~ack_tog;
					next_resp_len = 6'h0;
					next_last_mode = req_mode;
					if (!(dyn_en && !conn_en)) begin
						unique case (req_mode)
							PSE_M_POS: begin
								next_resp_word = pos_val;
								next_resp_len = {1'b0, res};
							end
							PSE_M_SEL: next_area = req_word[23:16];
							PSE_M_RECV: op_we = is_oem(area);
							PSE_M_RST: next_area = 8'h0;
							PSE_M_SEND: begin
								next_resp_len = `PSE_PAR_LEN;
								next_resp_word = 32'h0;
								if (is_oem(area)) begin
									next_ack_tog = ack_tog;
									next_sstate = PSE_S_READ;
								end else if (area == `PSE_AREA_STD && req_word[23:16] == `PSE_PAR_VER) begin
									next_resp_word = rev16(PROTO_VER);
								end else if (area == `PSE_AREA_STD && req_word[23:16] == `PSE_PAR_RES) begin
									next_resp_word = rev16({11'h0, res});
								end else if (area == `PSE_AREA_CMD && req_word[23:16] == `PSE_PAR_CMDSET) begin
									next_resp_word = rev16(CMD_SET);
								end
							end
							default: next_resp_len = 6'h0;
						endcase
					end
				end
			end
			PSE_S_READ: begin
				next_resp_word = rev16(mem_rdata);
				next_ack_tog = ~ack_tog;
				next_sstate = PSE_S_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			res <= `PSE_RES_DEF;
			dyn_en <= 1'b0;
			tmo_us <= `PSE_TMO_DEF_US;
			rdata <= 32'h0;
			area <= 8'h0;
			last_mode <= 3'h0;
			idle_cnt <= 18'h0;
			abort_tog <= 1'b0;
			abort_pend <= 1'b0;
			ack_tog <= 1'b0;
			resp_word <= 32'h0;
			resp_len <= 6'h0;
			sstate <= PSE_S_IDLE;
			turn <= 32'h0;
		end else begin
			res <= next_res;
			dyn_en <= next_dyn_en;
			tmo_us <= next_tmo_us;
			rdata <= next_rdata;
			area <= next_area;
			last_mode <= next_last_mode;
			idle_cnt <= next_idle_cnt;
			abort_tog <= next_abort_tog;
			abort_pend <= next_abort_pend;
			ack_tog <= next_ack_tog;
			resp_word <= next_resp_word;
			resp_len <= next_resp_len;
			sstate <= next_sstate;
			turn <= next_turn;
		end
	end

	assign reg_rdata = rdata;

	pse_mem u_mem (
		.clk_sys(clk_sys),
		.we(mem_we),
		.waddr(mem_waddr),
		.wdata(mem_wdata),
		.raddr(mem_raddr),
		.rdata(mem_rdata)
	);
endmodule

// [test/pse_ctrl_model.sv]
// Purpose: controller side of the serial position link, clock source and command sender
// Assumes: link clock period 64 ns, still between frames
// Notes: data changes while the clock is low; the reply is sampled just before the falling edge
`timescale 1ns/1ps
module pse_ctrl_model (
	// link towards the sensor
	output logic link_clk,
	output logic data_to_dev,
	// link from the sensor
	input wire logic data_from_dev,
	input wire logic oe_from_dev
);
	initial begin
		link_clk = 1'b0;
		data_to_dev = 1'b0;
	end

	// free pulses, only used around reset so the link side sees its reset
	task automatic pulse(input int n);
		repeat (n) begin
			#32 link_clk = 1'b1;
			#32 link_clk = 1'b0;
		end
	endtask

	// one frame: lead-in, mode bits and inverses, optional address and value, then reply capture
	task automatic frame(input logic [2:0] m, input logic bad, input logic [7:0] a, input logic [15:0] v,
		input int n, output logic got, output logic [31:0] w);
		logic [29:0] bits;
		int nb;
		int k;
		int last;
		bits = {m, ~m ^ {3{bad}}, a, v};
		nb = (m == 3'h0) ? 6 : 30;
		// with no reply due, stop on the edge that returns the sensor to lead-in, or it frames noise
		last = (n == 0) ? nb + 6 : nb + 40;
		k = 0;
		got = 1'b0;
		w = 32'h0;
		for (int e = 1; e <= last && !(k > n && !oe_from_dev); e++) begin
			// outside the command the line is not held, so it toggles rather than keeping its last bit
			data_to_dev = (e > 3 && e <= nb + 3) ? bits[29 - (e - 4)] : ~data_to_dev;
			#32 link_clk = 1'b1;
			#31;
			if (oe_from_dev && k == 0)
				got = data_from_dev;
			else if (oe_from_dev && k <= n)
				w = (m == 3'h0) ? w | (data_from_dev << (k - 1)) : {w[30:0], data_from_dev};
			if (oe_from_dev || k > 0)
				k++;
			#1 link_clk = 1'b0;
		end
	endtask
endmodule

// [test/pse_sensor_chk.sv]
// Purpose: port level properties of the sensor emulator
// Assumes: bound to the top module, register port and link side
// Notes: timeout limit offset 0x4, control 0x0, preload 0xc
`timescale 1ns/1ps
module pse_sensor_chk (
	// system
	input wire logic clk_sys,
	input wire logic reset,
	// register port
	input wire logic [3:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [31:0] reg_rdata,
	// link
	input wire logic link_clk,
	input wire logic link_data_out,
	input wire logic link_data_oe
);
	logic [5:0] oe_run;
	logic [5:0] next_oe_run;

	// length of the current reply burst, start bit included
	always_comb begin
		next_oe_run = link_data_oe ? oe_run + 6'h1 : 6'h0;
	end
	always_ff @(posedge link_clk) begin
		if (reset)
			oe_run <= 6'h0;
		else
			oe_run <= next_oe_run;
	end

	sequence s_wr_hi;
		reg_wr && reg_addr == 4'h4 && reg_wdata > 32'h28a;
	endsequence
	sequence s_wr_lo;
		reg_wr && reg_addr == 4'h4 && reg_wdata < 32'ha;
	endsequence
	sequence s_wr_in;
		reg_wr && reg_addr == 4'h4 && reg_wdata >= 32'ha && reg_wdata <= 32'h28a;
	endsequence
	sequence s_rd_tmo;
		!reg_wr ##1 reg_rd && reg_addr == 4'h4;
	endsequence

	tmo_high_a: assert property (@(posedge clk_sys) disable iff (reset)
		s_wr_hi ##1 s_rd_tmo |=> reg_rdata == 32'h28a) else $error("limit above range not clamped");
	tmo_low_a: assert property (@(posedge clk_sys) disable iff (reset)
		s_wr_lo ##1 s_rd_tmo |=> reg_rdata == 32'ha) else $error("limit below range not clamped");
	tmo_keep_a: assert property (@(posedge clk_sys) disable iff (reset)
		s_wr_in ##1 s_rd_tmo |=> reg_rdata == $past(reg_wdata, 3)) else $error("limit in range not kept");
	tmo_range_a: assert property (@(posedge clk_sys) disable iff (reset)
		reg_rd && reg_addr == 4'h4 |=> reg_rdata >= 32'ha && reg_rdata <= 32'h28a) else $error("limit out of range");
	ctrl_read_a: assert property (@(posedge clk_sys) disable iff (reset)
		reg_rd && reg_addr == 4'h0 |=> reg_rdata[31:6] == 26'h0) else $error("control word too wide");
	pre_read_a: assert property (@(posedge clk_sys) disable iff (reset)
		reg_rd && reg_addr == 4'hc |=> reg_rdata == 32'h0) else $error("preload port not write only");
	oe_start_a: assert property (@(posedge link_clk) disable iff (reset)
		$rose(link_data_oe) |-> link_data_out) else $error("reply without start bit");
	oe_len_a: assert property (@(posedge link_clk) disable iff (reset)
		oe_run <= 6'h20) else $error("reply longer than 31 bits");
	out_quiet_a: assert property (@(posedge link_clk) disable iff (reset)
		!link_data_oe |-> !link_data_out) else $error("data driven while released");
endmodule

// [test/test_pse_sensor.sv]
// Purpose: self checking bench of the sensor emulator with a controller model
// Assumes: timeout unit shortened to 2 cycles per microsecond
// Notes: link clock runs only inside frames and in the free pulses around reset
`timescale 1ns/1ps
module test_pse_sensor import pse_pkg::*; ;
	logic clk_sys = 1'b0;
	logic reset;
	logic [3:0] reg_addr;
	logic [31:0] reg_wdata;
	logic reg_wr;
	logic reg_rd;
	logic [31:0] reg_rdata;
	logic [31:0] angle_rad;
	logic conn_en;
	wire logic link_clk;
	wire logic link_data_in;
	logic link_data_out;
	logic link_data_oe;
	int error_cnt = 0;
	int num_checks = 0;
	int cyc = 0;
	logic [31:0] seed = 32'h4a9e;
	logic [31:0] q;
	logic [31:0] w;
	logic got;
	logic [31:0] tw [6] = '{32'h5, 32'h2bc, 32'ha, 32'h28a, 32'h3ff, 32'h14};
	logic [31:0] tx [6] = '{32'ha, 32'h28a, 32'ha, 32'h28a, 32'h28a, 32'h14};

	pse_sensor #(.CYC_PER_US(2)) DUT (.clk_sys(clk_sys), .reset(reset), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.angle_rad(angle_rad), .conn_en(conn_en), .link_clk(link_clk), .link_data_in(link_data_in),
		.link_data_out(link_data_out), .link_data_oe(link_data_oe));
	pse_ctrl_model u_ctl (.link_clk(link_clk), .data_to_dev(link_data_in), .data_from_dev(link_data_out),
		.oe_from_dev(link_data_oe));

	always #2 clk_sys = ~clk_sys;

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	// whole turn scaled to 2^32 from a Q3.29 angle, then top res bits
	function automatic logic [31:0] exp_pos(input logic [31:0] a, input int r);
		longint unsigned k;
		longint unsigned t;
		k = $rtoi((2.0 ** 32) / (2.0 * 3.141592653589793));
		t = ({32'h0, a} * k) >> 29;
		return t[31:0] >> (32 - r);
	endfunction

	task automatic complete_run();
		$display("checks %0d mismatches %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// one access; read data taken in the cycle after the strobe
	task automatic acc(input logic wr, input logic [3:0] a, input logic [31:0] d, output logic [31:0] r);
		@(posedge clk_sys);
		reg_wr <= wr;
		reg_rd <= ~wr;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
		reg_rd <= 1'b0;
		#1 r = reg_rdata;
	endtask

	// n of 0 means no reply is expected
	task automatic xfer(input logic [2:0] m, input logic [7:0] a, input logic [15:0] v, input int n,
		input logic [31:0] ew);
		u_ctl.frame(m, 1'b0, a, v, n, got, w);
		check("reply start", {31'h0, got}, {31'h0, n != 0});
		if (n != 0)
			check("reply word", w, ew);
	endtask

	// ceiling well above the expected length of the sequence
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 90000) begin
			error_cnt++;
			complete_run();
		end
	end

	initial begin
		logic [7:0] code;
		logic [7:0] wa;
		logic [15:0] wv;
		logic [15:0] rv;
		int r;
		logic [31:0] ang;
		reset = 1'b1;
		reg_addr = 4'h0;
		reg_wdata = 32'h0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		angle_rad = 32'h0;
		conn_en = 1'b1;
		// link side resets through its own synchroniser, so its clock must run meanwhile
		u_ctl.pulse(6);
		@(posedge clk_sys);
		reset <= 1'b0;
		// two edges clear the link reset synchroniser; a third would already count as lead-in
		u_ctl.pulse(2);
		#1000;
		foreach (tx[i]) begin
			acc(1'b0, 4'(i * 4), 32'h0, q);
			check("reset value", q, (i == 0) ? 32'h14 : (i == 1) ? 32'h64 : 32'h0);
			if (i == 3)
				break;
		end
		acc(1'b0, 4'h2, 32'h0, q);
		check("unmapped", q, 32'h0);
		foreach (tw[i]) begin
			acc(1'b1, 4'h4, tw[i], q);
			acc(1'b0, 4'h4, 32'h0, q);
			check("limit", q, tx[i]);
		end
		for (int i = 0; i < 6; i++) begin
			r = (i == 0) ? 1 : (i == 1) ? 31 : (i == 2) ? 20 : int'(rnd() % 31) + 1;
			ang = (i == 0) ? 32'h0 : (i == 1) ? 32'hc90fdaa2 : rnd() % 32'hc90fdaa2;
			acc(1'b1, 4'h0, 32'(r), q);
			@(posedge clk_sys);
			angle_rad <= ang;
			xfer(PSE_M_POS, 8'h0, 16'h0, r, exp_pos(ang, r));
		end
		acc(1'b1, 4'h0, 32'h14, q);
		xfer(PSE_M_SEL, 8'ha1, 16'h0, 0, 32'h0);
		xfer(PSE_M_SEND, 8'h08, 16'h0, 16, 32'h1);
		acc(1'b1, 4'hc, {8'ha1, 8'h0d, 16'hbeef}, q);
		xfer(PSE_M_SEND, 8'h0d, 16'h0, 16, 32'h14);
		xfer(PSE_M_SEL, 8'ha5, 16'h0, 0, 32'h0);
		xfer(PSE_M_SEND, 8'h2a, 16'h0, 16, 32'h1);
		xfer(PSE_M_SEND, 8'h08, 16'h0, 16, 32'h0);
		for (int a = 0; a < 4; a++) begin
			code = 8'ha9 + 8'(2 * a);
			wa = (a == 0) ? 8'h0 : (a == 3) ? 8'hff : rnd();
			wv = rnd();
			rv = rnd();
			acc(1'b1, 4'hc, {code, wa, wv}, q);
			xfer(PSE_M_SEL, code, 16'h0, 0, 32'h0);
			xfer(PSE_M_RECV, wa ^ 8'h80, rv, 0, 32'h0);
			xfer(PSE_M_SEND, wa, 16'h0, 16, {16'h0, wv});
			xfer(PSE_M_SEND, wa ^ 8'h80, 16'h0, 16, {16'h0, rv});
		end
		xfer(PSE_M_RST, 8'h0, 16'h0, 0, 32'h0);
		acc(1'b0, 4'h8, 32'h0, q);
		check("area after reset", {24'h0, q[9:2]}, 32'h0);
		u_ctl.frame(PSE_M_POS, 1'b1, 8'h0, 16'h0, 20, got, w);
		check("bad inverse", {31'h0, got}, 32'h0);
		// idle shorter than the limit keeps the receiver halted
		#40;
		xfer(PSE_M_POS, 8'h0, 16'h0, 0, 32'h0);
		#1000;
		xfer(PSE_M_POS, 8'h0, 16'h0, 20, exp_pos(angle_rad, 20));
		@(posedge clk_sys);
		conn_en <= 1'b0;
		xfer(PSE_M_POS, 8'h0, 16'h0, 20, exp_pos(angle_rad, 20));
		acc(1'b1, 4'h0, 32'h34, q);
		xfer(PSE_M_POS, 8'h0, 16'h0, 0, 32'h0);
		@(posedge clk_sys);
		conn_en <= 1'b1;
		xfer(PSE_M_POS, 8'h0, 16'h0, 20, exp_pos(angle_rad, 20));
		complete_run();
	end
endmodule

bind pse_sensor pse_sensor_chk u_chk (.clk_sys(clk_sys), .reset(reset), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.link_clk(link_clk), .link_data_out(link_data_out), .link_data_oe(link_data_oe));
